// *** rtl/frc_pkg.sv ***
package frc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RATE   = 8'h04;
  localparam logic [7:0] ADDR_CHUNK  = 8'h08;
  localparam logic [7:0] ADDR_FRAME  = 8'h0c;
  localparam logic [7:0] ADDR_EXPO   = 8'h10;
  localparam logic [7:0] ADDR_UPPER  = 8'h14;
  localparam logic [7:0] ADDR_LOWER  = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_TRIG_EN  = 1;
  localparam int CTRL_PRESERVE = 2;
  localparam int CTRL_BULK     = 3;
  localparam int STAT_RUN      = 0;
  localparam int STAT_BUSY     = 1;
  localparam int STAT_EXPO     = 2;
  localparam int STAT_CNT_LSB  = 16;

  // ----------------------------------------------------------------
  // reset values and rate bounds
  // ----------------------------------------------------------------
  localparam logic        PRESERVE_RST = 1'b1;
  localparam logic [15:0] RATE_RST     = 16'h0001;
  localparam logic [15:0] UPPER_RST    = 16'h0001;
  localparam logic [15:0] CHUNK_RST    = 16'h0000;
  localparam logic [31:0] FRAME_RST    = 32'h0000_0000;
  localparam logic [31:0] EXPO_RST     = 32'h0000_0000;
  localparam logic [15:0] RATE_LOWER   = 16'h0001;
  localparam logic [15:0] RATE_CEIL    = 16'hffff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 10;
  localparam logic [31:0] CLK_HZ         = 32'(1_000_000_000 / CLK_PERIOD_NS);
  localparam int          MICROFRAME_US  = 125;
  localparam logic [31:0] MICROFRAMES_PS = 32'(1_000_000 / MICROFRAME_US);
  localparam logic [4:0]  DIV_LAST       = 5'h1f;

  typedef enum logic [1:0] {
    FRC_IDLE  = 2'b00,
    FRC_DIV   = 2'b01,
    FRC_APPLY = 2'b10
  } frc_state_type;

endpackage

// *** rtl/frc_frame_rate_controller.sv ***
`timescale 1ns/100ps
module frc_frame_rate_controller
  import frc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        frame_trigger_i,
  output logic             frame_start_o,
  output logic             exposing_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic          run;
  logic          trig_en;
  logic          rate_preservation_flag;
  logic          bulk_mode;
  logic [15:0]   acquisition_rate;
  logic [15:0]   acquisition_rate_upper_limit;
  logic [15:0]   transfer_chunk_size;
  logic [31:0]   frame_bytes;
  logic [31:0]   exposure;
  logic [15:0]   active_rate;
  logic [31:0]   phase_acc;
  logic [31:0]   expo_cnt;
  logic [15:0]   frame_count;
  logic          recompute_pend;
  frc_state_type state;
  logic [31:0]   div_num;
  logic [31:0]   div_den;
  logic [32:0]   div_rem;
  logic [31:0]   div_quot;
  logic [4:0]    div_cnt;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic access;
  logic mapped;
  logic locked;
  logic wr_ok;
  logic rate_wr;
  logic size_wr;
  logic [15:0] wr_rate;

  assign access   = psel_i & penable_i;
  assign mapped   = (paddr_i[1:0] == 2'b00) && (paddr_i <= ADDR_STATUS);
  // video mode sizes may change only while stopped; rate is exempt
  assign locked   = run && ((paddr_i == ADDR_CHUNK) || (paddr_i == ADDR_FRAME));
  assign wr_ok    = access & pwrite_i & mapped & ~locked;
  assign rate_wr  = wr_ok && (paddr_i == ADDR_RATE);
  assign size_wr  = wr_ok && ((paddr_i == ADDR_CHUNK) || (paddr_i == ADDR_FRAME));
  assign pready_o = 1'b1;
  assign pslverr_o = access & (~mapped | (pwrite_i & locked));

  // out-of-range writes are clamped into the allowed window
  assign wr_rate = (pwdata_i[15:0] < RATE_LOWER) ? RATE_LOWER :
                   (pwdata_i[15:0] > acquisition_rate_upper_limit) ?
                   acquisition_rate_upper_limit : pwdata_i[15:0];

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      run                    <= 1'b0;
      trig_en                <= 1'b0;
      rate_preservation_flag <= PRESERVE_RST;
      bulk_mode              <= 1'b0;
    end
    else if (wr_ok && (paddr_i == ADDR_CTRL))
    begin
      run                    <= pwdata_i[CTRL_RUN];
      trig_en                <= pwdata_i[CTRL_TRIG_EN];
      rate_preservation_flag <= pwdata_i[CTRL_PRESERVE];
      bulk_mode              <= pwdata_i[CTRL_BULK];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      transfer_chunk_size <= CHUNK_RST;
      frame_bytes         <= FRAME_RST;
      exposure            <= EXPO_RST;
    end
    else if (wr_ok)
    begin
      if (paddr_i == ADDR_CHUNK)
        transfer_chunk_size <= pwdata_i[15:0];
      if (paddr_i == ADDR_FRAME)
        frame_bytes <= pwdata_i;
      if (paddr_i == ADDR_EXPO)
        exposure <= pwdata_i;
    end
  end

  // read data is captured in the setup phase so it is stable at access
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      case (paddr_i)
        ADDR_CTRL:   prdata_o <= {28'h0000000, bulk_mode, rate_preservation_flag,
                                  trig_en, run};
        ADDR_RATE:   prdata_o <= {16'h0000, acquisition_rate};
        ADDR_CHUNK:  prdata_o <= {16'h0000, transfer_chunk_size};
        ADDR_FRAME:  prdata_o <= frame_bytes;
        ADDR_EXPO:   prdata_o <= exposure;
        ADDR_UPPER:  prdata_o <= {16'h0000, acquisition_rate_upper_limit};
        ADDR_LOWER:  prdata_o <= {16'h0000, RATE_LOWER};
        ADDR_STATUS: prdata_o <= {frame_count, 13'h0000, exposing_o,
                                  (state != FRC_IDLE) | recompute_pend, run};
        default:     prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // upper limit recompute: chunk * 8000 / frame bytes
  // ----------------------------------------------------------------
  logic [32:0] rem_shift;
  logic        quot_bit;
  logic [32:0] next_rem;
  logic [15:0] next_upper;

  assign rem_shift = {div_rem[31:0], div_num[31]};
  assign quot_bit  = (rem_shift >= {1'b0, div_den});
  assign next_rem  = quot_bit ? (rem_shift - {1'b0, div_den}) : rem_shift;
  assign next_upper = ((div_den == 32'h0000_0000) || (div_quot[31:16] != 16'h0000)) ?
                      RATE_CEIL :
                      (div_quot[15:0] < RATE_LOWER) ? RATE_LOWER : div_quot[15:0];

  // a size write landing during a running divide is never lost
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      recompute_pend <= 1'b0;
    else
      recompute_pend <= (recompute_pend & (state != FRC_IDLE)) | size_wr;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state    <= FRC_IDLE;
      div_num  <= 32'h0000_0000;
      div_den  <= 32'h0000_0000;
      div_rem  <= 33'h0_0000_0000;
      div_quot <= 32'h0000_0000;
      div_cnt  <= 5'h00;
    end
    else
    begin
      case (state)
        FRC_IDLE:
          if (recompute_pend)
          begin
            // bulk and isochronous share the same per-micro-frame average
            div_num  <= 32'(transfer_chunk_size) * MICROFRAMES_PS;
            div_den  <= frame_bytes;
            div_rem  <= 33'h0_0000_0000;
            div_quot <= 32'h0000_0000;
            div_cnt  <= 5'h00;
            state    <= FRC_DIV;
          end
        FRC_DIV:
        begin
          div_rem  <= next_rem;
          div_num  <= {div_num[30:0], 1'b0};
          div_quot <= {div_quot[30:0], quot_bit};
          div_cnt  <= div_cnt + 5'h01;
          if (div_cnt == DIV_LAST)
            state <= FRC_APPLY;
        end
        FRC_APPLY:
          state <= FRC_IDLE;
        default:
          state <= FRC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      acquisition_rate_upper_limit <= UPPER_RST;
    else if (state == FRC_APPLY)
      acquisition_rate_upper_limit <= next_upper;
  end

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      acquisition_rate <= RATE_RST;
    else if (state == FRC_APPLY)
    begin
      if (!rate_preservation_flag || (acquisition_rate > next_upper))
        acquisition_rate <= next_upper;
    end
    else if (rate_wr)
      acquisition_rate <= wr_rate;
  end

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  logic period_due;
  logic free_fire;
  logic trig_fire;
  logic frame_fire;

  assign exposing_o = (expo_cnt != 32'h0000_0000);
  assign period_due = (phase_acc >= CLK_HZ);
  assign free_fire  = run & ~trig_en & period_due & ~exposing_o;
  assign trig_fire  = run & trig_en & frame_trigger_i;
  assign frame_fire = free_fire | trig_fire;

  // accumulator adds the rate each cycle in free run (cleared when stopped or triggered) except while a due frame waits out exposure, one frame per CLK_HZ
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_acc <= 32'h0000_0000;
    else if (!run || trig_en)
      phase_acc <= 32'h0000_0000;
    else if (free_fire)
      phase_acc <= phase_acc - CLK_HZ + 32'(active_rate);
    else if (!period_due)
      phase_acc <= phase_acc + 32'(active_rate);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      active_rate <= RATE_RST;
    else if (!run || frame_fire)
      active_rate <= acquisition_rate;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      expo_cnt <= 32'h0000_0000;
    else if (frame_fire)
      expo_cnt <= exposure;
    else if (exposing_o)
      expo_cnt <= expo_cnt - 32'h0000_0001;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      frame_start_o <= 1'b0;
      frame_count   <= 16'h0000;
    end
    else
    begin
      frame_start_o <= frame_fire;
      if (frame_fire)
        frame_count <= frame_count + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_trig_pace;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (run && trig_en) |=> (frame_start_o == $past(frame_trigger_i));
  endproperty
  a_trig_pace: assert property (p_trig_pace) else $error("trigger pacing broken");
  property p_lower_read;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == ADDR_LOWER)
      |=> (prdata_o == 32'h0000_0001);
  endproperty
  a_lower_read: assert property (p_lower_read) else $error("lower limit not one");
  property p_size_recompute;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (size_wr && state == FRC_IDLE && !recompute_pend) |=> ##1 (state == FRC_DIV) ##32
      (state == FRC_APPLY);
  endproperty
  a_size_recompute: assert property (p_size_recompute) else $error("no recompute");
  property p_rate_live;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (run && rate_wr && state != FRC_APPLY) |=> (acquisition_rate == $past(wr_rate));
  endproperty
  a_rate_live: assert property (p_rate_live) else $error("rate write lost");
  property p_expo_hold;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (frame_fire && exposure > 32'h0000_0002) |=> !free_fire [*2];
  endproperty
  a_expo_hold: assert property (p_expo_hold) else $error("period not stretched");
  property p_preserve;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == FRC_APPLY && rate_preservation_flag && acquisition_rate <= next_upper)
      |=> $stable(acquisition_rate);
  endproperty
  a_preserve: assert property (p_preserve) else $error("rate not kept");
  property p_maximise;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == FRC_APPLY && !rate_preservation_flag)
      |=> (acquisition_rate == acquisition_rate_upper_limit);
  endproperty
  a_maximise: assert property (p_maximise) else $error("rate not maximised");
  property p_boundary;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (run && !frame_fire) |=> (active_rate == $past(active_rate));
  endproperty
  a_boundary: assert property (p_boundary) else $error("rate changed mid-frame");
endmodule

// *** tb/frc_host_model.sv ***
`timescale 1ns/100ps
module frc_host_model
  import frc_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  output logic             trigger_o
);
  // 48 KiB per micro-frame is the whole controller's share
  localparam logic [31:0] CHUNK_CAP = 32'h0000_c000;

  initial
  begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
    trigger_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus and trigger
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge sys_clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= a;
    pwdata_o  <= (wr && a == ADDR_CHUNK && d > CHUNK_CAP) ? CHUNK_CAP : d;
    @(posedge sys_clk_i);
    penable_o <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 50);
    q = prdata_i;
    err = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    if (pready_i !== 1'b1)
      test_frame_rate_controller.abort("bus hang");
  endtask

  task automatic pulse();
    @(posedge sys_clk_i);
    trigger_o <= 1'b1;
    @(posedge sys_clk_i);
    trigger_o <= 1'b0;
  endtask
endmodule

// *** tb/test_frame_rate_controller.sv ***
`timescale 1ns/100ps
module test_frame_rate_controller
  import frc_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic        fstart;
  logic        expo;
  int          num_errors = 0;
  int          checks_done = 0;
  int          n;

  always #5 sys_clk = ~sys_clk;

  frc_frame_rate_controller frc_frame_rate_controller_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .frame_trigger_i(trig),
    .frame_start_o(fstart), .exposing_o(expo));

  frc_host_model frc_host_model_i (
    .sys_clk_i(sys_clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .trigger_o(trig));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic abort(input string m);
    num_errors++;
    $display("CHECK FAILED %0t %s", $time, m);
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi, input string m);
    checks_done++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    frc_host_model_i.xfer(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ee}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    frc_host_model_i.xfer(1'b0, a, 32'h0, q, e);
    chk({31'h0, e}, 32'h0, "read response");
    chk(q, exp, "read data");
  endtask

  // recompute needs about 35 cycles after the size write
  task automatic settle();
    repeat (40) @(posedge sys_clk);
  endtask

  // sampled just after the edge so the registered pulse has landed
  task automatic wait_frame(input int lim, input logic must, output int c);
    c = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end while (fstart !== 1'b1 && c < lim);
    if (must && fstart !== 1'b1)
      abort("no frame");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_CTRL, 32'h0000_0004);
    rd(ADDR_LOWER, 32'h0000_0001);
    rd(ADDR_UPPER, 32'h0000_0001);
    wr(ADDR_LOWER, 32'h0000_0005, 1'b0);
    rd(ADDR_LOWER, 32'h0000_0001);
    wr(ADDR_UPPER, 32'h0000_0005, 1'b0);
    rd(ADDR_UPPER, 32'h0000_0001);
    wr(8'h20, 32'h0000_0001, 1'b1);
  endtask

  task automatic t_recompute();
    wr(ADDR_CHUNK, 32'h0000_0064, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0002);
    settle();
    rd(ADDR_UPPER, 32'h0000_ffff);
    rd(ADDR_RATE, 32'h0000_0001);
    wr(ADDR_FRAME, 32'h0000_1f40, 1'b0);
    settle();
    rd(ADDR_UPPER, 32'h0000_0064);
    rd(ADDR_RATE, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0008, 1'b0);
    wr(ADDR_CHUNK, 32'h0000_00c8, 1'b0);
    settle();
    rd(ADDR_UPPER, 32'h0000_00c8);
    rd(ADDR_RATE, 32'h0000_00c8);
    wr(ADDR_CTRL, 32'h0000_0004, 1'b0);
    wr(ADDR_CHUNK, 32'h0000_0032, 1'b0);
    settle();
    rd(ADDR_RATE, 32'h0000_0032);
  endtask

  task automatic t_freerun();
    wr(ADDR_FRAME, 32'h0000_0000, 1'b0);
    settle();
    wr(ADDR_RATE, 32'h0000_ffff, 1'b0);
    rd(ADDR_RATE, 32'h0000_ffff);
    wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
    wait_frame(2000, 1'b1, n);
    chk_in(n, 1520, 1530, "first period");
    wait_frame(2000, 1'b1, n);
    chk_in(n, 1525, 1527, "free period");
    frc_host_model_i.pulse();
    #1;
    chk({31'h0, fstart}, 32'h0, "trigger in free run");
    wr(ADDR_RATE, 32'h0000_8000, 1'b0);
    wr(ADDR_CHUNK, 32'h0000_0005, 1'b1);
    wait_frame(2000, 1'b1, n);
    wait_frame(4000, 1'b1, n);
    chk_in(n, 3050, 3054, "new rate period");
    wr(ADDR_EXPO, 32'h0000_1388, 1'b0);
    wait_frame(4000, 1'b1, n);
    chk({31'h0, expo}, 32'h1, "exposing");
    wait_frame(6000, 1'b1, n);
    chk_in(n, 4999, 5004, "stretched period");
  endtask

  task automatic t_trigger();
    wr(ADDR_EXPO, 32'h0000_0000, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
    wait_frame(6000, 1'b0, n);
    chk_in(n, 6000, 6000, "rate paced frame in trigger mode");
    frc_host_model_i.pulse();
    #1;
    chk({31'h0, fstart}, 32'h1, "trigger frame");
    wait_frame(4000, 1'b0, n);
    chk_in(n, 4000, 4000, "frame without trigger");
    wr(ADDR_CTRL, 32'h0000_0002, 1'b0);
    frc_host_model_i.pulse();
    #1;
    chk({31'h0, fstart}, 32'h0, "trigger while stopped");
    rd(ADDR_STATUS, 32'h0007_0000);
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_recompute();
    t_freerun();
    t_trigger();
    give_verdict();
  end
endmodule
